// ===== rtl/gate_drive_brake.sv
// Implementation choices: register access over APB and the register offsets.
`include "gdrv_cfg.svh"

module gate_drive_brake #(
  parameter int PHASES = 3,
  parameter int CW = 4,
  parameter int TW = 8,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pwm inputs and brake triggers
  input wire logic [PHASES-1:0] high_pwm_in,
  input wire logic [PHASES-1:0] low_pwm_in,
  input wire logic brake_request_n,
  input wire logic overcurrent_fault,
  input wire logic watchdog_fault,
  // gate commands
  output logic [PHASES-1:0] high_gate_out,
  output logic [PHASES-1:0] low_gate_out,
  // gate current selection
  output logic [PHASES*CW-1:0] hi_gate_current,
  output logic [PHASES-1:0] hi_gate_full,
  output logic [PHASES*CW-1:0] lo_gate_current,
  output logic [PHASES-1:0] lo_gate_full
);
  gdrv_pkg::brake_mode_e brake_mode_q;
  logic [TW-1:0] deadtime_rising_q;
  logic [TW-1:0] deadtime_falling_q;
  logic [CW-1:0] hi_side_turnon_current_q;
  logic [CW-1:0] hi_side_turnoff_current_q;
  logic [CW-1:0] lo_side_turnon_current_q;
  logic [CW-1:0] lo_side_turnoff_current_q;
  logic [CW-1:0] precharge_current_q;
  logic [CW-1:0] predischarge_current_q;
  logic precharge_current_use_q;
  logic predischarge_current_use_q;
  logic [TW-1:0] precharge_duration_q;
  logic [TW-1:0] turnon_slew_duration_q;
  logic [TW-1:0] predischarge_duration_q;
  logic [TW-1:0] turnoff_slew_duration_q;
  logic brake_cond;
  logic brake_active_q;
  logic alt_side_q;
  logic side_high;
  logic side_hiz;
  logic [PHASES-1:0] hi_req;
  logic [PHASES-1:0] lo_req;
  logic wr_en;
  logic rd_setup;
  logic [TW-1:0] dt_min;

  slew_cfg_if #(.CW(CW), .TW(TW)) slew_cfg ();

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADDR_W'(`ADDR_BRAKE_CFG), ADDR_W'(`ADDR_DEADTIME), ADDR_W'(`ADDR_SLEW_CUR),
      ADDR_W'(`ADDR_SLEW_TIME), ADDR_W'(`ADDR_STATUS): is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  assign dt_min = TW'(`DT_MIN_CYC);

  // ---------------- apb slave ----------------
  // zero wait states: the access phase always completes
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign wr_en = psel & penable & pwrite & is_mapped(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;

  // brake mode may change at any time and acts at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_mode_q <= gdrv_pkg::brake_mode_e'(`RST_BRK_MODE);
    end else if (wr_en && paddr == ADDR_W'(`ADDR_BRAKE_CFG)) begin
      brake_mode_q <= gdrv_pkg::brake_mode_e'(pwdata[`BRK_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deadtime_rising_q <= TW'(`RST_DT);
      deadtime_falling_q <= TW'(`RST_DT);
    end else if (wr_en && paddr == ADDR_W'(`ADDR_DEADTIME)) begin
      deadtime_rising_q <= pwdata[`DEADTIME_RISING_LSB +: TW];
      deadtime_falling_q <= pwdata[`DEADTIME_FALLING_LSB +: TW];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_side_turnon_current_q <= CW'(`RST_CUR);
      hi_side_turnoff_current_q <= CW'(`RST_CUR);
      lo_side_turnon_current_q <= CW'(`RST_CUR);
      lo_side_turnoff_current_q <= CW'(`RST_CUR);
      precharge_current_q <= CW'(`RST_CUR);
      predischarge_current_q <= CW'(`RST_CUR);
      precharge_current_use_q <= 1'b0;
      predischarge_current_use_q <= 1'b0;
    end else if (wr_en && paddr == ADDR_W'(`ADDR_SLEW_CUR)) begin
      hi_side_turnon_current_q <= pwdata[`HS_ON_LSB +: CW];
      hi_side_turnoff_current_q <= pwdata[`HS_OFF_LSB +: CW];
      lo_side_turnon_current_q <= pwdata[`LS_ON_LSB +: CW];
      lo_side_turnoff_current_q <= pwdata[`LS_OFF_LSB +: CW];
      precharge_current_q <= pwdata[`PRE_SRC_LSB +: CW];
      predischarge_current_q <= pwdata[`PRE_SNK_LSB +: CW];
      precharge_current_use_q <= pwdata[`PRE_SRC_USE_BIT];
      predischarge_current_use_q <= pwdata[`PRE_SNK_USE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      precharge_duration_q <= TW'(`RST_TDRIVE);
      turnon_slew_duration_q <= TW'(`RST_TDRIVE);
      predischarge_duration_q <= TW'(`RST_TDRIVE);
      turnoff_slew_duration_q <= TW'(`RST_TDRIVE);
    end else if (wr_en && paddr == ADDR_W'(`ADDR_SLEW_TIME)) begin
      precharge_duration_q <= pwdata[`T1_LSB +: TW];
      turnon_slew_duration_q <= pwdata[`T2_LSB +: TW];
      predischarge_duration_q <= pwdata[`T3_LSB +: TW];
      turnoff_slew_duration_q <= pwdata[`T4_LSB +: TW];
    end
  end

  // read data is captured in the setup phase so it is stable for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= 32'h0;
      case (paddr)
        ADDR_W'(`ADDR_BRAKE_CFG): prdata[`BRK_MODE_LSB +: 2] <= brake_mode_q;
        ADDR_W'(`ADDR_DEADTIME): begin
          prdata[`DEADTIME_RISING_LSB +: TW] <= deadtime_rising_q;
          prdata[`DEADTIME_FALLING_LSB +: TW] <= deadtime_falling_q;
        end
        ADDR_W'(`ADDR_SLEW_CUR): begin
          prdata[`HS_ON_LSB +: CW] <= hi_side_turnon_current_q;
          prdata[`HS_OFF_LSB +: CW] <= hi_side_turnoff_current_q;
          prdata[`LS_ON_LSB +: CW] <= lo_side_turnon_current_q;
          prdata[`LS_OFF_LSB +: CW] <= lo_side_turnoff_current_q;
          prdata[`PRE_SRC_LSB +: CW] <= precharge_current_q;
          prdata[`PRE_SNK_LSB +: CW] <= predischarge_current_q;
          prdata[`PRE_SRC_USE_BIT] <= precharge_current_use_q;
          prdata[`PRE_SNK_USE_BIT] <= predischarge_current_use_q;
        end
        ADDR_W'(`ADDR_SLEW_TIME): begin
          prdata[`T1_LSB +: TW] <= precharge_duration_q;
          prdata[`T2_LSB +: TW] <= turnon_slew_duration_q;
          prdata[`T3_LSB +: TW] <= predischarge_duration_q;
          prdata[`T4_LSB +: TW] <= turnoff_slew_duration_q;
        end
        ADDR_W'(`ADDR_STATUS): begin
          prdata[0] <= brake_active_q;
          prdata[1] <= side_high;
          prdata[2] <= ~brake_request_n;
          prdata[3] <= overcurrent_fault;
          prdata[4] <= watchdog_fault;
          prdata[8 +: PHASES] <= high_gate_out;
          prdata[12 +: PHASES] <= low_gate_out;
        end
        default: prdata <= 32'h0;
      endcase
    end
  end

  // one shared settings set feeds every driver
  assign slew_cfg.hs_on = hi_side_turnon_current_q;
  assign slew_cfg.hs_off = hi_side_turnoff_current_q;
  assign slew_cfg.ls_on = lo_side_turnon_current_q;
  assign slew_cfg.ls_off = lo_side_turnoff_current_q;
  assign slew_cfg.pre_src = precharge_current_q;
  assign slew_cfg.pre_snk = predischarge_current_q;
  assign slew_cfg.pre_src_use = precharge_current_use_q;
  assign slew_cfg.pre_snk_use = predischarge_current_use_q;
  assign slew_cfg.t1 = precharge_duration_q;
  assign slew_cfg.t2 = turnon_slew_duration_q;
  assign slew_cfg.t3 = predischarge_duration_q;
  assign slew_cfg.t4 = turnoff_slew_duration_q;

  // ---------------- brake control ----------------
  // the pin is trusted to idle high; any low level counts at once
  assign brake_cond = ~brake_request_n | overcurrent_fault | watchdog_fault;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brake_active_q <= 1'b0;
    end else begin
      brake_active_q <= brake_cond;
    end
  end

  // side flips when the unregistered condition rises, together with brake_active_q, so the first event brakes high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_side_q <= 1'b0;
    end else if (brake_cond && !brake_active_q) begin
      alt_side_q <= ~alt_side_q;
    end
  end

  assign side_hiz = (brake_mode_q == gdrv_pkg::BRAKE_HIZ);
  assign side_high = (brake_mode_q == gdrv_pkg::BRAKE_HIGH) |
    ((brake_mode_q == gdrv_pkg::BRAKE_ALT) & alt_side_q);

  // brake pattern overrides pwm; dead time unit handles the hand-over
  assign hi_req = brake_active_q ? {PHASES{side_high & ~side_hiz}} : high_pwm_in;
  assign lo_req = brake_active_q ? {PHASES{~side_high & ~side_hiz}} : low_pwm_in;

  // ---------------- per-phase drivers ----------------
  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    deadtime_unit #(.DW(TW)) u_dt (
      .pclk(pclk),
      .presetn(presetn),
      .hi_req(hi_req[p]),
      .lo_req(lo_req[p]),
      .deadtime_rising(deadtime_rising_q),
      .deadtime_falling(deadtime_falling_q),
      .dt_min(dt_min),
      .hi_gate(high_gate_out[p]),
      .lo_gate(low_gate_out[p])
    );
    slew_sequencer #(.HIGH_SIDE(1'b1), .CW(CW), .TW(TW)) u_hi (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(slew_cfg),
      .gate_on(high_gate_out[p]),
      .gate_current(hi_gate_current[p*CW +: CW]),
      .gate_full(hi_gate_full[p])
    );
    slew_sequencer #(.HIGH_SIDE(1'b0), .CW(CW), .TW(TW)) u_lo (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(slew_cfg),
      .gate_on(low_gate_out[p]),
      .gate_current(lo_gate_current[p*CW +: CW]),
      .gate_full(lo_gate_full[p])
    );
  end

  // ---------------- checks ----------------
  // own both-off run length of phase 0, kept apart from the dead time units
  logic [TW-1:0] off_run_q;
  logic [TW-1:0] rise_floor;
  logic [TW-1:0] fall_floor;

  assign rise_floor = (deadtime_rising_q < dt_min) ? dt_min : deadtime_rising_q;
  assign fall_floor = (deadtime_falling_q < dt_min) ? dt_min : deadtime_falling_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_run_q <= '0;
    end else if (high_gate_out[0] | low_gate_out[0]) begin
      off_run_q <= '0;
    end else if (off_run_q != '1) begin
      off_run_q <= off_run_q + TW'(1);
    end
  end

  a_brake_trigger: assert property (@(posedge pclk) disable iff (!presetn)
    brake_cond |=> brake_active_q)
    else $error("brake trigger not registered");
  a_brake_high_side: assert property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && brake_mode_q == gdrv_pkg::BRAKE_HIGH |=> low_gate_out == '0)
    else $error("low gates on during high-side braking");
  a_brake_low_side: assert property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && brake_mode_q == gdrv_pkg::BRAKE_LOW |=> high_gate_out == '0)
    else $error("high gates on during low-side braking");
  a_alt_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(brake_active_q) |-> alt_side_q != $past(alt_side_q))
    else $error("alternate side did not flip");
  a_side_high_on: assert property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && side_high && !side_hiz |=> low_gate_out == '0)
    else $error("low gates on while braking high");
  a_side_low_on: assert property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && !side_high && !side_hiz |=> high_gate_out == '0)
    else $error("high gates on while braking low");
  a_brake_hiz: assert property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && side_hiz |=> high_gate_out == '0 && low_gate_out == '0)
    else $error("gate on during non-power braking");
  a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == ADDR_W'(`ADDR_BRAKE_CFG)
    |=> brake_mode_q == $past(pwdata[`BRK_MODE_LSB +: 2]))
    else $error("brake mode write not applied");
  a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
    (high_gate_out & low_gate_out) == '0)
    else $error("both gates of a phase on");
  a_rise_gap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(high_gate_out[0]) |-> $past(off_run_q) >= $past(rise_floor) - TW'(1))
    else $error("rising dead time shorter than programmed");
  a_fall_gap: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(low_gate_out[0]) |-> $past(off_run_q) >= $past(fall_floor) - TW'(1))
    else $error("falling dead time shorter than programmed");
  a_min_dead_hi: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(high_gate_out[0]) |-> $past(low_gate_out[0], 1) == 1'b0
      && $past(low_gate_out[0], 2) == 1'b0)
    else $error("high gate rose inside minimum dead time");
  a_min_dead_lo: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(low_gate_out[0]) |-> $past(high_gate_out[0], 1) == 1'b0
      && $past(high_gate_out[0], 2) == 1'b0)
    else $error("low gate rose inside minimum dead time");
  a_brake_sequence: assert property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && low_gate_out[0] && side_high && !side_hiz
    |=> !low_gate_out[0] ##1 !high_gate_out[0])
    else $error("braking side turned on without dead time");
  a_brake_seq_low: assert property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && high_gate_out[0] && !side_high && !side_hiz
    |=> !high_gate_out[0] ##1 !low_gate_out[0])
    else $error("low braking side turned on without dead time");

  c_brake_high: cover property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && high_gate_out == '1);
  c_brake_low: cover property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && low_gate_out == '1);
  c_brake_hiz: cover property (@(posedge pclk) disable iff (!presetn)
    brake_active_q && side_hiz);
  c_alt_flip: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(brake_active_q) && brake_mode_q == gdrv_pkg::BRAKE_ALT);
  c_resume_pwm: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(brake_active_q) ##[1:300] $rose(high_gate_out[0]));
endmodule // gate_drive_brake

// ===== rtl/gdrv_cfg.svh
`ifndef GDRV_CFG_SVH
`define GDRV_CFG_SVH

// register byte offsets
`define ADDR_BRAKE_CFG 8'h00
`define ADDR_DEADTIME 8'h04
`define ADDR_SLEW_CUR 8'h08
`define ADDR_SLEW_TIME 8'h0C
`define ADDR_STATUS 8'h10

// field positions
`define BRK_MODE_LSB 0
`define DEADTIME_RISING_LSB 0
`define DEADTIME_FALLING_LSB 8
`define HS_ON_LSB 0
`define HS_OFF_LSB 4
`define LS_ON_LSB 8
`define LS_OFF_LSB 12
`define PRE_SRC_LSB 16
`define PRE_SNK_LSB 20
`define PRE_SRC_USE_BIT 24
`define PRE_SNK_USE_BIT 25
`define T1_LSB 0
`define T2_LSB 8
`define T3_LSB 16
`define T4_LSB 24

// reset values
`define RST_BRK_MODE 2'h1
`define RST_DT 8'h04
`define RST_CUR 4'h8
`define RST_TDRIVE 8'h04

// timing
`define CLK_PERIOD_NS 50
`define DT_MIN_NS 100
`define DT_MIN_CYC ((`DT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/gdrv_pkg.sv
package gdrv_pkg;
  typedef enum logic [1:0] {
    BRAKE_HIGH = 2'h0,
    BRAKE_LOW = 2'h1,
    BRAKE_ALT = 2'h2,
    BRAKE_HIZ = 2'h3
  } brake_mode_e;

  typedef enum logic [5:0] {
    S_OFF_FULL = 6'h01,
    S_PRE_ON = 6'h02,
    S_SLEW_ON = 6'h04,
    S_ON_FULL = 6'h08,
    S_PRE_OFF = 6'h10,
    S_SLEW_OFF = 6'h20
  } slew_state_e;
endpackage

// ===== rtl/slew_cfg_if.sv
interface slew_cfg_if #(
  parameter int CW = 4,
  parameter int TW = 8
);
  logic [CW-1:0] hs_on;
  logic [CW-1:0] hs_off;
  logic [CW-1:0] ls_on;
  logic [CW-1:0] ls_off;
  logic [CW-1:0] pre_src;
  logic [CW-1:0] pre_snk;
  logic pre_src_use;
  logic pre_snk_use;
  logic [TW-1:0] t1;
  logic [TW-1:0] t2;
  logic [TW-1:0] t3;
  logic [TW-1:0] t4;
  modport src (output hs_on, hs_off, ls_on, ls_off, pre_src, pre_snk, pre_src_use,
    pre_snk_use, t1, t2, t3, t4);
  modport dst (input hs_on, hs_off, ls_on, ls_off, pre_src, pre_snk, pre_src_use,
    pre_snk_use, t1, t2, t3, t4);
endinterface

// ===== rtl/deadtime_unit.sv
module deadtime_unit #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requested pattern
  input wire logic hi_req,
  input wire logic lo_req,
  // timing
  input wire logic [DW-1:0] deadtime_rising,
  input wire logic [DW-1:0] deadtime_falling,
  input wire logic [DW-1:0] dt_min,
  // gate commands
  output logic hi_gate,
  output logic lo_gate
);
  logic [DW-1:0] cnt_q;
  logic [DW-1:0] eff_rise;
  logic [DW-1:0] eff_fall;
  logic hi_d;
  logic lo_d;

  // programmed values never undercut the floor
  assign eff_rise = (deadtime_rising < dt_min) ? dt_min : deadtime_rising;
  assign eff_fall = (deadtime_falling < dt_min) ? dt_min : deadtime_falling;

  // turn-off is immediate, turn-on waits for the opposite side to be dead long enough
  assign hi_d = hi_req & ~lo_req & ~lo_gate & (hi_gate | (cnt_q >= eff_rise - DW'(1)));
  assign lo_d = lo_req & ~hi_req & ~hi_gate & (lo_gate | (cnt_q >= eff_fall - DW'(1)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_gate <= 1'b0;
      lo_gate <= 1'b0;
    end else begin
      hi_gate <= hi_d;
      lo_gate <= lo_d;
    end
  end

  // counts cycles with both switches off, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (hi_gate | lo_gate) begin
      cnt_q <= '0;
    end else if (cnt_q != {DW{1'b1}}) begin
      cnt_q <= cnt_q + DW'(1);
    end
  end
endmodule // deadtime_unit

// ===== rtl/slew_sequencer.sv
module slew_sequencer #(
  parameter bit HIGH_SIDE = 1'b1,
  parameter int CW = 4,
  parameter int TW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // shared settings
  slew_cfg_if.dst cfg,
  // gate command
  input wire logic gate_on,
  // current selection
  output logic [CW-1:0] gate_current,
  output logic gate_full
);
  gdrv_pkg::slew_state_e state_q, state_d;
  logic gate_on_q;
  logic [TW-1:0] cnt_q, cnt_d;
  logic [TW-1:0] t_slew_q;
  logic [CW-1:0] pre_cur_q;
  logic [CW-1:0] slew_cur_q;
  logic pre_use_q;
  logic start_on;
  logic start_off;
  logic last;

  assign start_on = gate_on & ~gate_on_q;
  assign start_off = ~gate_on & gate_on_q;
  assign last = (cnt_q == TW'(1));

  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - TW'(1);
    if (start_on) begin
      // zero durations skip their phase
      if (cfg.t1 != '0) begin
        state_d = gdrv_pkg::S_PRE_ON;
        cnt_d = cfg.t1;
      end else if (cfg.t2 != '0) begin
        state_d = gdrv_pkg::S_SLEW_ON;
        cnt_d = cfg.t2;
      end else begin
        state_d = gdrv_pkg::S_ON_FULL;
      end
    end else if (start_off) begin
      if (cfg.t3 != '0) begin
        state_d = gdrv_pkg::S_PRE_OFF;
        cnt_d = cfg.t3;
      end else if (cfg.t4 != '0) begin
        state_d = gdrv_pkg::S_SLEW_OFF;
        cnt_d = cfg.t4;
      end else begin
        state_d = gdrv_pkg::S_OFF_FULL;
      end
    end else begin
      case (state_q)
        gdrv_pkg::S_PRE_ON: begin
          if (last) begin
            state_d = (t_slew_q != '0) ? gdrv_pkg::S_SLEW_ON : gdrv_pkg::S_ON_FULL;
            cnt_d = t_slew_q;
          end
        end
        gdrv_pkg::S_SLEW_ON: begin
          if (last) state_d = gdrv_pkg::S_ON_FULL;
        end
        gdrv_pkg::S_PRE_OFF: begin
          if (last) begin
            state_d = (t_slew_q != '0) ? gdrv_pkg::S_SLEW_OFF : gdrv_pkg::S_OFF_FULL;
            cnt_d = t_slew_q;
          end
        end
        gdrv_pkg::S_SLEW_OFF: begin
          if (last) state_d = gdrv_pkg::S_OFF_FULL;
        end
        gdrv_pkg::S_ON_FULL, gdrv_pkg::S_OFF_FULL: state_d = state_q;
        default: state_d = gdrv_pkg::S_OFF_FULL;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= gdrv_pkg::S_OFF_FULL;
      cnt_q <= '0;
      gate_on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      gate_on_q <= gate_on;
    end
  end

  // settings are sampled only at a switching edge, never mid-transition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_slew_q <= '0;
      pre_cur_q <= '0;
      slew_cur_q <= '0;
      pre_use_q <= 1'b0;
    end else if (start_on) begin
      t_slew_q <= cfg.t2;
      pre_cur_q <= cfg.pre_src;
      pre_use_q <= cfg.pre_src_use;
      slew_cur_q <= HIGH_SIDE ? cfg.hs_on : cfg.ls_on;
    end else if (start_off) begin
      t_slew_q <= cfg.t4;
      pre_cur_q <= cfg.pre_snk;
      pre_use_q <= cfg.pre_snk_use;
      slew_cur_q <= HIGH_SIDE ? cfg.hs_off : cfg.ls_off;
    end
  end

  // outputs follow the next state so they line up with state_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_current <= '0;
      gate_full <= 1'b1;
    end else begin
      case (state_d)
        gdrv_pkg::S_PRE_ON, gdrv_pkg::S_PRE_OFF: begin
          gate_current <= start_on ? cfg.pre_src : (start_off ? cfg.pre_snk : pre_cur_q);
          gate_full <= start_on ? ~cfg.pre_src_use : (start_off ? ~cfg.pre_snk_use :
            ~pre_use_q);
        end
        gdrv_pkg::S_SLEW_ON, gdrv_pkg::S_SLEW_OFF: begin
          gate_current <= start_on ? (HIGH_SIDE ? cfg.hs_on : cfg.ls_on) :
            (start_off ? (HIGH_SIDE ? cfg.hs_off : cfg.ls_off) : slew_cur_q);
          gate_full <= 1'b0;
        end
        default: begin
          gate_current <= '0;
          gate_full <= 1'b1;
        end
      endcase
    end
  end

  a_precharge_entry: assert property (@(posedge pclk) disable iff (!presetn)
    start_on && cfg.t1 != '0 |=> state_q == gdrv_pkg::S_PRE_ON)
    else $error("precharge not entered on turn-on");
  a_zero_slew_skip: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == gdrv_pkg::S_PRE_ON && last && t_slew_q == '0 && gate_on
    |=> state_q == gdrv_pkg::S_ON_FULL && gate_full)
    else $error("zero slew duration not skipped");
  a_precharge_full: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == gdrv_pkg::S_PRE_ON && !pre_use_q |-> gate_full)
    else $error("precharge not at full current while disabled");
endmodule // slew_sequencer

// ===== bench/mcu_model.sv
module mcu_model (
  // clock
  input wire logic pclk,
  // requests from the sequence
  input wire logic [2:0] hi_cmd,
  input wire logic [2:0] lo_cmd,
  input wire logic brake_cmd,
  // pins into the driver
  output logic [2:0] high_pwm_in,
  output logic [2:0] low_pwm_in,
  output logic brake_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // no gap of our own: the driver must supply the dead time
  always @(posedge pclk) begin
    high_pwm_in <= hi_cmd & ~lo_cmd;
    low_pwm_in <= lo_cmd;
  end
  // pin high in normal running, low only while braking is wanted
  always @(posedge pclk) brake_request_n <= ~brake_cmd;
endmodule // mcu_model

// ===== bench/gate_drive_brake_tb.sv
module gate_drive_brake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, brk, ocf, wdf, brn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] hc, lc, hpi, lpi, hgo, lgo, hfull, lfull;
  logic [11:0] hcur, lcur;
  logic [31:0] rst_val [5] = '{32'h1, 32'h0404, 32'h0088_8888, 32'h0404_0404, 32'h0};
  int failures = 0;
  int compares = 0;
  int dr, df;

  gate_drive_brake dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_pwm_in(hpi), .low_pwm_in(lpi), .brake_request_n(brn),
    .overcurrent_fault(ocf), .watchdog_fault(wdf), .high_gate_out(hgo), .low_gate_out(lgo),
    .hi_gate_current(hcur), .hi_gate_full(hfull), .lo_gate_current(lcur), .lo_gate_full(lfull));
  mcu_model mcu_u (.pclk(pclk), .hi_cmd(hc), .lo_cmd(lc), .brake_cmd(brk),
    .high_pwm_in(hpi), .low_pwm_in(lpi), .brake_request_n(brn));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      failures++;
      end_of_test;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    bound(n, 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic gates(input logic [2:0] eh, input logic [2:0] el);
    int n;
    n = 0;
    while ({hgo, lgo} !== {eh, el} && n < 40) begin
      @(posedge pclk);
      n++;
    end
    check(32'({hgo, lgo}), 32'({eh, el}));
    bound(n, 40);
  endtask

  task automatic trig(input int src, input logic v);
    if (src == 0) brk <= v;
    else if (src == 1) ocf <= v;
    else wdf <= v;
  endtask

  // start from the side opposite to the one braking is meant to reach
  task automatic brake(input int src, input logic hi, input logic [2:0] eh, input logic [2:0] el);
    hc <= hi ? 3'h7 : 3'h0;
    lc <= hi ? 3'h0 : 3'h7;
    gates(hi ? 3'h7 : 3'h0, hi ? 3'h0 : 3'h7);
    trig(src, 1'b1);
    gates(eh, el);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, {17'h0, el, 1'b0, eh, 3'h0, 3'(1 << src), |eh, 1'b1});
    trig(src, 1'b0);
    gates(hi ? 3'h7 : 3'h0, hi ? 3'h0 : 3'h7);
  endtask

  task automatic gap(input logic hs, input int exp);
    int n;
    n = 0;
    while ((hgo[0] | lgo[0]) !== 1'b0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    bound(n, 40);
    n = 0;
    while ((hs ? hgo[0] : lgo[0]) !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n), 32'(exp));
  endtask

  // cycles spent on each expected current code, per side of phase 0
  task automatic slew(input logic [3:0] hpc, hsc, lpc, lsc, input int hp, hs, lp, ls);
    int c[4] = '{0, 0, 0, 0};
    repeat (40) begin
      @(posedge pclk);
      if (hfull[0] === 1'b0 && hcur[3:0] === hpc) c[0]++;
      if (hfull[0] === 1'b0 && hcur[3:0] === hsc) c[1]++;
      if (lfull[0] === 1'b0 && lcur[3:0] === lpc) c[2]++;
      if (lfull[0] === 1'b0 && lcur[3:0] === lsc) c[3]++;
    end
    check(32'(c[0]), 32'(hp));
    check(32'(c[1]), 32'(hs));
    check(32'(c[2]), 32'(lp));
    check(32'(c[3]), 32'(ls));
  endtask

  always @(negedge pclk)
    if (presetn === 1'b1) check(32'(hgo & lgo), 32'h0);

  initial begin
    void'($urandom(47934));
    {presetn, psel, penable, pwrite, brk, ocf, wdf} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    hc = 3'h0;
    lc = 3'h7;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, (i == 4) ? 8'h14 : 8'(i * 4), 32'h0);
      check(rd, rst_val[i]);
      check(32'(err), 32'(i == 4));
    end
    // alternate mode must be first: high side on the first event
    apb(1'b1, 8'h00, 32'h2);
    for (int e = 0; e < 3; e++)
      brake(e, e[0], e[0] ? 3'h0 : 3'h7, e[0] ? 3'h7 : 3'h0);
    apb(1'b1, 8'h00, 32'h0);
    brake(0, 1'b0, 3'h7, 3'h0);
    apb(1'b1, 8'h00, 32'h1);
    brake(1, 1'b1, 3'h0, 3'h7);
    apb(1'b1, 8'h00, 32'h3);
    brake(2, 1'b0, 3'h0, 3'h0);
    for (int k = 0; k < 3; k++) begin
      dr = (k == 0) ? 0 : 2 + $urandom % 8;
      df = (k == 0) ? 1 : 2 + $urandom % 8;
      apb(1'b1, 8'h04, 32'((df << 8) | dr));
      hc <= 3'h7;
      lc <= 3'h0;
      gap(1'b1, (dr < 2) ? 2 : dr);
      hc <= 3'h0;
      lc <= 3'h7;
      gap(1'b0, (df < 2) ? 2 : df);
    end
    apb(1'b1, 8'h08, 32'h0321_6543);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) apb(1'b1, 8'h08, 32'h0021_6543);
      apb(1'b1, 8'h0C, (k == 1) ? 32'h0402_0003 : 32'h0402_0503);
      hc <= 3'h7;
      lc <= 3'h0;
      slew(4'h1, 4'h3, 4'h2, 4'h6, (k == 2) ? 0 : 3, (k == 1) ? 0 : 5, (k == 2) ? 0 : 2, 4);
      hc <= 3'h0;
      lc <= 3'h7;
      slew(4'h2, 4'h4, 4'h1, 4'h5, (k == 2) ? 0 : 2, 4, (k == 2) ? 0 : 3, (k == 1) ? 0 : 5);
    end
    end_of_test;
  end
endmodule // gate_drive_brake_tb
